// ==== sc_defines.svh ====
// Purpose: constants for the supply controller two-wire target
// Assumes: included by bare name, once per compilation unit
// Notes:   offsets, fields, reset values and address bits
//
// Contract
// - target acknowledges every byte addressed to it outside lockout
// - write keeps accepting bytes until stop
// - only index one accepts written data
// - read sends bytes while controller acknowledges
// - index zero status, index one control
// - stop after any acknowledge abandons cleanly
// - control reads back last written byte
// - control bits 0-2 select output level
// - control bit 3 drives converter compensation
// - control clears to zero at power-on
// - status register is read only
// - status bit 0 shows overload
// - status bit 1 shows overtemperature
// - status bit 2 shows output low
// - status bit 3 shows input low
// - status bit 4 shows pulldown overcurrent
// - status reads zero after power-on
// - address low bits match configured selection
// - no acknowledge during supply undervoltage lockout
// - bytes are eight bits msb first, ack
`ifndef SC_DEFINES_SVH
`define SC_DEFINES_SVH

// ********************************************
// register indices and reset values
// ********************************************
`define SC_IDX_STATUS   1'h0
`define SC_IDX_CTRL     1'h1
`define SC_CTRL_RESET   8'h00
`define SC_STATUS_RESET 8'h00

// ********************************************
// control fields
// ********************************************
`define SC_LEVEL_BIT0   0
`define SC_LEVEL_BIT1   1
`define SC_LEVEL_BIT2   2
`define SC_COMP_BIT     3

// ********************************************
// target address and bit counting
// ********************************************
`define SC_ADDR_FIXED   5'h02
`define SC_FLAG_W       5
`define SC_LAST_BIT     4'h7
`define SC_BYTE_BITS    4'h8

`endif

// ==== sc_host_model.sv ====
// Purpose: behavioural two-wire bus controller for the bench
// Assumes: device pulls sda low through sda_oe; pull-up otherwise
// Notes:   scl idles high between frames; steps on clk falling edge
`timescale 1ns/1ps
`default_nettype none
module sc_host_model (
  // timing reference
  input  wire logic clk,
  // device side of the data line
  input  wire logic sda_oe,
  // wired bus levels
  output logic      scl,
  output logic      sda
);
  logic pull_low; // controller pulls sda low

  // open drain with pull-up, both parties
  assign sda = ~(pull_low | sda_oe);

  // bus idle at time zero
  initial begin
    scl = 1'h1;
    pull_low = 1'h0;
  end

  // ****************************************
  // bit level steps
  // ****************************************
  // one quarter bit is eight clk cycles
  task automatic qtr(input int n);
    repeat (n * 8) @(negedge clk);
  endtask

  // sda falls while scl high
  task automatic start_c();
    pull_low = 1'h0;
    qtr(1);
    scl = 1'h1;
    qtr(1);
    pull_low = 1'h1;
    qtr(1);
    scl = 1'h0;
    qtr(1);
  endtask

  // sda rises while scl high
  task automatic stop_c();
    pull_low = 1'h1;
    qtr(1);
    scl = 1'h1;
    qtr(1);
    pull_low = 1'h0;
    qtr(2);
  endtask

  // data changes only while scl low
  task automatic bit_o(input logic b);
    pull_low = ~b;
    qtr(1);
    scl = 1'h1;
    qtr(2);
    scl = 1'h0;
    qtr(1);
  endtask

  // release sda and sample mid high phase
  task automatic bit_i(output logic b);
    pull_low = 1'h0;
    qtr(1);
    scl = 1'h1;
    qtr(1);
    b = sda;
    qtr(1);
    scl = 1'h0;
    qtr(1);
  endtask

  // ****************************************
  // byte level steps
  // ****************************************
  // eight bits msb first, then the ack slot
  task automatic byte_o(input logic [7:0] d, output logic ack);
    logic a;
    for (int i = 7; i >= 0; i--) begin
      bit_o(d[i]);
    end
    bit_i(a);
    ack = ~a;
  endtask

  // read eight bits, then ack low or leave high
  task automatic byte_i(output logic [7:0] d, input logic ack);
    for (int i = 7; i >= 0; i--) begin
      bit_i(d[i]);
    end
    bit_o(~ack);
  endtask
endmodule
`default_nettype wire

// ==== sc_pkg.sv ====
// Purpose: shared types for the supply controller target
// Assumes: nothing
// Notes:   link-side transfer states
`default_nettype none
package sc_pkg;
  // link-side transfer phases
  typedef enum logic [3:0] {
    ST_IDLE,
    ST_RX_ADDR,
    ST_ACK_ADDR,
    ST_RX_IDX,
    ST_ACK_IDX,
    ST_RX_DATA,
    ST_ACK_DATA,
    ST_TX,
    ST_RD_ACK
  } sc_state_e;
endpackage
`default_nettype wire

// ==== sc_sync.sv ====
// Purpose: two-flop level synchroniser
// Assumes: slow-changing or independent bits
// Notes:   first stage feeds only the second stage
`timescale 1ns/1ps
`default_nettype none
module sc_sync #(
  parameter int W = 1
) (
  // clock and reset
  input  wire logic         clk,
  input  wire logic         reset,
  // data
  input  wire logic [W-1:0] d,
  output logic      [W-1:0] q
);
  logic [W-1:0] meta_ff;  // first stage, read only by q

  // ********************************************
  // two stages
  // ********************************************
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      meta_ff <= '0;
      q       <= '0;
    end else begin
      meta_ff <= d;
      q       <= meta_ff;
    end
  end
endmodule
`default_nettype wire

// ==== sc_target_regs.sv ====
// Purpose: two-wire target with control and status registers
// Assumes: link_clk oversamples scl and sda; clk runs the registers
// Notes:   sda is open drain, driven low only while sda_oe is high
`timescale 1ns/1ps
`default_nettype none
`include "sc_defines.svh"
module sc_target_regs (
  // system clock and reset
  input  wire logic       clk,
  input  wire logic       reset,
  // link oversampling clock
  input  wire logic       link_clk,
  // two-wire pins
  input  wire logic       scl_in,
  input  wire logic       sda_in,
  output logic            sda_out,
  output logic            sda_oe,
  // configuration straps
  input  wire logic [1:0] addr_sel,
  input  wire logic       uvlo_active,
  // analog detector flags
  input  wire logic       overload_flag,
  input  wire logic       overtemp_flag,
  input  wire logic       output_low_flag,
  input  wire logic       input_low_flag,
  input  wire logic       pulldown_overcurrent_flag,
  // converter controls
  output logic            level_sel_bit0,
  output logic            level_sel_bit1,
  output logic            level_sel_bit2,
  output logic            comp_sel
);
  import sc_pkg::*;

  // ********************************************
  // link-domain declarations
  // ********************************************
  logic [4:0]  pin_s;         // synced scl, sda, uvlo, addr_sel
  logic        scl_s;         // synced scl
  logic        sda_s;         // synced sda
  logic        uvlo_s;        // synced lockout
  logic [1:0]  addr_sel_s;    // synced address straps
  logic        scl_d_ff;      // scl one cycle back
  logic        sda_d_ff;      // sda one cycle back
  logic [7:0]  status_lk;     // status seen in link domain
  sc_state_e   state_ff;      // transfer phase
  sc_state_e   nxt_state;
  logic [3:0]  cnt_ff;        // bit counter
  logic [3:0]  nxt_cnt;
  logic [7:0]  shift_ff;      // receive shifter
  logic [7:0]  nxt_shift;
  logic [7:0]  tx_shift_ff;   // transmit shifter
  logic [7:0]  nxt_tx_shift;
  logic        sda_oe_ff;     // pull sda low
  logic        nxt_sda_oe;
  logic        sda_out_ff;    // level driven when enabled
  logic        ptr_ff;        // register index
  logic        nxt_ptr;
  logic        rw_ff;         // direction of transfer
  logic        nxt_rw;
  logic [7:0]  wr_data_ff;    // last written control byte
  logic [7:0]  nxt_wr_data;
  logic        wr_tgl_ff;     // toggles on each control write
  logic        nxt_wr_tgl;
  logic        nack_ff;       // controller left ack high
  logic        nxt_nack;

  // ********************************************
  // link-domain decode
  // ********************************************
  wire start_det  = scl_s & scl_d_ff & sda_d_ff & ~sda_s;
  wire stop_det   = scl_s & scl_d_ff & ~sda_d_ff & sda_s;
  wire scl_rise   = scl_s & ~scl_d_ff;
  wire scl_fall   = ~scl_s & scl_d_ff;
  wire byte_full  = (cnt_ff == `SC_BYTE_BITS);
  wire tx_last    = (cnt_ff == `SC_LAST_BIT);
  // address match on fixed bits and straps, refused in lockout
  wire addr_hit   = (shift_ff[7:1] == {`SC_ADDR_FIXED, addr_sel_s}) & ~uvlo_s;
  // current and following register contents
  wire [7:0] cur_byte = (ptr_ff == `SC_IDX_CTRL) ? wr_data_ff : status_lk;
  wire [7:0] nxt_byte = (ptr_ff == `SC_IDX_CTRL) ? status_lk : wr_data_ff;
  wire in_rx = (state_ff == ST_RX_ADDR) | (state_ff == ST_RX_IDX) | (state_ff == ST_RX_DATA);

  assign scl_s      = pin_s[4];
  assign sda_s      = pin_s[3];
  assign uvlo_s     = pin_s[2];
  assign addr_sel_s = pin_s[1:0];

  // pins pass two flops before use
  sc_sync #(.W(5)) u_pin_sync (
    .clk   (link_clk),
    .reset (reset),
    .d     ({scl_in, sda_in, uvlo_active, addr_sel}),
    .q     (pin_s)
  );

  // ********************************************
  // link-domain next state
  // ********************************************
  always_comb begin
    nxt_state    = state_ff;
    nxt_cnt      = cnt_ff;
    nxt_shift    = shift_ff;
    nxt_tx_shift = tx_shift_ff;
    nxt_sda_oe   = sda_oe_ff;
    nxt_ptr      = ptr_ff;
    nxt_rw       = rw_ff;
    nxt_wr_data  = wr_data_ff;
    nxt_wr_tgl   = wr_tgl_ff;
    nxt_nack     = nack_ff;
    if (start_det) begin
      // start or repeated start: expect an address
      nxt_state  = ST_RX_ADDR;
      nxt_cnt    = 4'h0;
      nxt_sda_oe = 1'b0;
    end else if (stop_det) begin
      // stop ends any phase and frees sda
      nxt_state  = ST_IDLE;
      nxt_cnt    = 4'h0;
      nxt_sda_oe = 1'b0;
    end else if (in_rx) begin
      if (scl_rise) begin
        // sample one bit, msb first
        nxt_shift = {shift_ff[6:0], sda_s};
        nxt_cnt   = cnt_ff + 4'h1;
      end else if (scl_fall && byte_full) begin
        nxt_cnt = 4'h0;
        if (state_ff == ST_RX_ADDR) begin
          // address byte: answer only on a match
          nxt_rw     = shift_ff[0];
          nxt_sda_oe = addr_hit;
          nxt_state  = addr_hit ? ST_ACK_ADDR : ST_IDLE;
        end else if (state_ff == ST_RX_IDX) begin
          // index byte: low bit picks the register
          nxt_ptr    = shift_ff[0];
          nxt_sda_oe = ~uvlo_s;
          nxt_state  = ST_ACK_IDX;
        end else begin
          // data byte: stored only at the control index
          if (ptr_ff == `SC_IDX_CTRL) begin
            nxt_wr_data = shift_ff;
            nxt_wr_tgl  = ~wr_tgl_ff;
          end
          nxt_sda_oe = ~uvlo_s;
          nxt_state  = ST_ACK_DATA;
        end
      end
    end else if (state_ff == ST_ACK_ADDR) begin
      if (scl_fall) begin
        if (rw_ff) begin
          // read: snapshot the selected byte, drive its msb
          nxt_tx_shift = cur_byte;
          nxt_sda_oe   = ~cur_byte[7];
          nxt_state    = ST_TX;
        end else begin
          nxt_sda_oe = 1'b0;
          nxt_state  = ST_RX_IDX;
        end
      end
    end else if ((state_ff == ST_ACK_IDX) || (state_ff == ST_ACK_DATA)) begin
      if (scl_fall) begin
        // further data bytes keep coming until stop
        nxt_sda_oe = 1'b0;
        nxt_state  = ST_RX_DATA;
      end
    end else if (state_ff == ST_TX) begin
      if (scl_fall) begin
        if (tx_last) begin
          // release sda for the controller's ack
          nxt_sda_oe = 1'b0;
          nxt_cnt    = 4'h0;
          nxt_state  = ST_RD_ACK;
        end else begin
          nxt_cnt      = cnt_ff + 4'h1;
          nxt_tx_shift = {tx_shift_ff[6:0], 1'b0};
          nxt_sda_oe   = ~tx_shift_ff[6];
        end
      end
    end else if (state_ff == ST_RD_ACK) begin
      if (scl_rise) begin
        nxt_nack = sda_s;
      end else if (scl_fall) begin
        if (nack_ff) begin
          // controller ends the read
          nxt_state = ST_IDLE;
        end else begin
          // continue with the following register
          nxt_ptr      = ~ptr_ff;
          nxt_tx_shift = nxt_byte;
          nxt_sda_oe   = ~nxt_byte[7];
          nxt_state    = ST_TX;
        end
      end
    end
  end

  // ********************************************
  // link-domain registers
  // ********************************************
  always_ff @(posedge link_clk or posedge reset) begin
    if (reset) begin
      scl_d_ff    <= 1'b1;
      sda_d_ff    <= 1'b1;
      state_ff    <= ST_IDLE;
      cnt_ff      <= 4'h0;
      shift_ff    <= 8'h00;
      tx_shift_ff <= 8'h00;
      sda_oe_ff   <= 1'b0;
      sda_out_ff  <= 1'b0;
      ptr_ff      <= `SC_IDX_STATUS;
      rw_ff       <= 1'b0;
      wr_data_ff  <= `SC_CTRL_RESET;
      wr_tgl_ff   <= 1'b0;
      nack_ff     <= 1'b0;
    end else begin
      scl_d_ff    <= scl_s;
      sda_d_ff    <= sda_s;
      state_ff    <= nxt_state;
      cnt_ff      <= nxt_cnt;
      shift_ff    <= nxt_shift;
      tx_shift_ff <= nxt_tx_shift;
      sda_oe_ff   <= nxt_sda_oe;
      sda_out_ff  <= 1'b0;
      ptr_ff      <= nxt_ptr;
      rw_ff       <= nxt_rw;
      wr_data_ff  <= nxt_wr_data;
      wr_tgl_ff   <= nxt_wr_tgl;
      nack_ff     <= nxt_nack;
    end
  end

  assign sda_oe  = sda_oe_ff;
  assign sda_out = sda_out_ff;

  // ********************************************
  // system-domain registers
  // ********************************************
  logic [`SC_FLAG_W-1:0] flag_s;    // synced detector flags
  logic [7:0]            status_ff; // diagnostic status
  logic [7:0]            ctrl_ff;   // output control
  logic                  tgl_s;     // synced write toggle
  logic                  tgl_d_ff;  // toggle one cycle back
  wire                   wr_seen = tgl_s ^ tgl_d_ff;

  // detector flags pass two flops
  sc_sync #(.W(`SC_FLAG_W)) u_flag_sync (
    .clk   (clk),
    .reset (reset),
    .d     ({pulldown_overcurrent_flag, input_low_flag, output_low_flag, overtemp_flag, overload_flag}),
    .q     (flag_s)
  );

  // write event crosses as a toggle
  sc_sync #(.W(1)) u_tgl_sync (
    .clk   (clk),
    .reset (reset),
    .d     (wr_tgl_ff),
    .q     (tgl_s)
  );

  // status back to the link side
  sc_sync #(.W(8)) u_stat_sync (
    .clk   (link_clk),
    .reset (reset),
    .d     (status_ff),
    .q     (status_lk)
  );

  // status follows flags, control takes held write data
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      status_ff <= `SC_STATUS_RESET;
      ctrl_ff   <= `SC_CTRL_RESET;
      tgl_d_ff  <= 1'b0;
    end else begin
      status_ff <= {3'h0, flag_s};
      ctrl_ff   <= wr_seen ? wr_data_ff : ctrl_ff;
      tgl_d_ff  <= tgl_s;
    end
  end

  // converter controls straight from the control flops
  assign level_sel_bit0 = ctrl_ff[`SC_LEVEL_BIT0];
  assign level_sel_bit1 = ctrl_ff[`SC_LEVEL_BIT1];
  assign level_sel_bit2 = ctrl_ff[`SC_LEVEL_BIT2];
  assign comp_sel       = ctrl_ff[`SC_COMP_BIT];

  // ********************************************
  // checks
  // ********************************************
  a_addr_ack_drive: assert property (@(posedge link_clk) disable iff (reset)
    (scl_fall && state_ff == ST_RX_ADDR && byte_full && addr_hit) |=> sda_oe_ff ##1 sda_oe_ff)
    else $error("address ack not driven");

  a_uvlo_no_ack: assert property (@(posedge link_clk) disable iff (reset)
    (scl_fall && in_rx && byte_full && uvlo_s) |=> !sda_oe_ff)
    else $error("ack driven during lockout");

  a_stop_release: assert property (@(posedge link_clk) disable iff (reset)
    stop_det |=> (state_ff == ST_IDLE) && !sda_oe_ff)
    else $error("stop did not release the bus");

  a_ctrl_write: assert property (@(posedge link_clk) disable iff (reset)
    (scl_fall && state_ff == ST_RX_DATA && byte_full && ptr_ff) |=>
      (wr_tgl_ff != $past(wr_tgl_ff)) && (wr_data_ff == $past(shift_ff)))
    else $error("control write not stored");

  a_status_ro: assert property (@(posedge link_clk) disable iff (reset)
    (scl_fall && state_ff == ST_RX_DATA && byte_full && !ptr_ff) |=> $stable(wr_tgl_ff) && $stable(wr_data_ff))
    else $error("status index altered control");

  a_tx_msb_first: assert property (@(posedge link_clk) disable iff (reset)
    (state_ff == ST_TX) |-> (sda_oe_ff == ~tx_shift_ff[7]))
    else $error("transmit bit mismatch");

  a_read_select: assert property (@(posedge link_clk) disable iff (reset)
    (scl_fall && state_ff == ST_ACK_ADDR && rw_ff && !start_det && !stop_det) |=>
      tx_shift_ff == ($past(ptr_ff) ? $past(wr_data_ff) : $past(status_lk)))
    else $error("wrong register loaded for read");

  a_nack_ends: assert property (@(posedge link_clk) disable iff (reset)
    (scl_fall && state_ff == ST_RD_ACK && nack_ff && !stop_det) |=> state_ff == ST_IDLE)
    else $error("read continued after nack");

  a_ctrl_update: assert property (@(posedge clk) disable iff (reset)
    wr_seen |=> ctrl_ff == $past(wr_data_ff) ##1 level_sel_bit0 == ctrl_ff[0])
    else $error("control not updated from write");

  a_status_reserved: assert property (@(posedge clk) disable iff (reset)
    status_ff[7:5] == 3'h0 && status_ff[4:0] == $past(flag_s))
    else $error("status does not follow flags");

  c_ctrl_write: cover property (@(posedge link_clk) disable iff (reset)
    (state_ff == ST_ACK_DATA) && ptr_ff);

  c_read_status: cover property (@(posedge link_clk) disable iff (reset)
    (state_ff == ST_TX) && !ptr_ff);

  c_read_continue: cover property (@(posedge link_clk) disable iff (reset)
    (state_ff == ST_RD_ACK) && scl_fall && !nack_ff);

  c_uvlo_refuse: cover property (@(posedge link_clk) disable iff (reset)
    scl_fall && (state_ff == ST_RX_ADDR) && byte_full && uvlo_s);
endmodule
`default_nettype wire

// ==== supply_ctrl_i2c_target_regs_bench.sv ====
// Purpose: self-checking bench for the supply controller target
// Assumes: host model drives the bus; flags and straps from here
// Notes:   inputs change on clk falling edge
`timescale 1ns/1ps
`default_nettype none
`include "sc_defines.svh"
module supply_ctrl_i2c_target_regs_bench;
  logic       clk, reset, link_clk, uvlo;
  logic [1:0] strap, host_sel; // device strap, address sent
  logic [4:0] flg;             // detector flags
  logic [7:0] ctrl_exp;        // expected control byte
  wire        scl, sda, sda_oe, lv0, lv1, lv2, comp;
  wire        sda_o;           // open drain low level, must stay 0
  int         bad_count, checked;

  sc_target_regs dut (.clk(clk), .reset(reset), .link_clk(link_clk), .scl_in(scl), .sda_in(sda),
    .sda_out(sda_o), .sda_oe(sda_oe), .addr_sel(strap), .uvlo_active(uvlo), .overload_flag(flg[0]),
    .overtemp_flag(flg[1]), .output_low_flag(flg[2]), .input_low_flag(flg[3]),
    .pulldown_overcurrent_flag(flg[4]), .level_sel_bit0(lv0), .level_sel_bit1(lv1),
    .level_sel_bit2(lv2), .comp_sel(comp));
  sc_host_model host (.clk(clk), .sda_oe(sda_oe), .scl(scl), .sda(sda));

  // two unrelated clocks
  always #2.5 clk = ~clk;
  always #3 link_clk = ~link_clk;

  // ****************************************
  // shared steps
  // ****************************************
  task automatic chk(input string what, input logic [7:0] seen, input logic [7:0] exp);
    checked++;
    if (seen !== exp) begin
      bad_count++;
      $display("ERROR %s expected %h seen %h", what, exp, seen);
    end
  endtask

  // index then two data bytes; every slot should match ack_exp
  task automatic wr(input logic [7:0] idx, input logic [7:0] d0, input logic [7:0] d1,
                    input logic ack_exp);
    logic a;
    host.start_c();
    host.byte_o({`SC_ADDR_FIXED, host_sel, 1'h0}, a);
    chk("address ack", {7'h0, a}, {7'h0, ack_exp});
    host.byte_o(idx, a);
    chk("index ack", {7'h0, a}, {7'h0, ack_exp});
    host.byte_o(d0, a);
    chk("data ack", {7'h0, a}, {7'h0, ack_exp});
    host.byte_o(d1, a);
    chk("second data ack", {7'h0, a}, {7'h0, ack_exp});
    host.stop_c();
    repeat (20) @(negedge clk);
  endtask

  // index write, stop, then read two bytes with ack then nack
  task automatic rd(input logic [7:0] idx, output logic [7:0] b0, output logic [7:0] b1);
    logic a;
    host.start_c();
    host.byte_o({`SC_ADDR_FIXED, host_sel, 1'h0}, a);
    host.byte_o(idx, a);
    host.stop_c();
    host.start_c();
    host.byte_o({`SC_ADDR_FIXED, host_sel, 1'h1}, a);
    chk("read address ack", {7'h0, a}, 8'h01);
    host.byte_i(b0, 1'h1);
    host.byte_i(b1, 1'h0);
    host.stop_c();
  endtask

  // converter outputs against the low control nibble, sda low level in bit 4
  task automatic outs(input logic [7:0] exp);
    chk("level outputs", {3'h0, sda_o, comp, lv2, lv1, lv0}, exp & 8'h0F);
  endtask

  // ****************************************
  // scenarios
  // ****************************************
  // everything clear after reset
  task automatic t_power();
    logic [7:0] s, c;
    outs(8'h00);
    rd(8'h00, s, c);
    chk("status at power-on", s, `SC_STATUS_RESET);
    chk("control at power-on", c, `SC_CTRL_RESET);
  endtask

  // every level code, compensation toggling, last byte wins
  task automatic t_levels();
    logic [7:0] s, c;
    for (int k = 0; k < 8; k++) begin
      ctrl_exp = {4'h0, k[0], k[2:0]};
      wr(8'h01, {4'h0, ~ctrl_exp[3:0]}, ctrl_exp, 1'h1);
      outs(ctrl_exp);
      rd(8'h01, c, s);
      chk("control readback", c, ctrl_exp);
      chk("status after control", s, 8'h00);
    end
  endtask

  // each flag alone, read from index zero then control follows
  task automatic t_status();
    logic [7:0] s, c;
    for (int i = 0; i < 5; i++) begin
      flg = 5'h01 << i;
      repeat (20) @(negedge clk);
      rd(8'h00, s, c);
      chk("status flag", s, {3'h0, flg});
      chk("control after status", c, ctrl_exp);
    end
  endtask

  // writes to the status index are acked and change nothing
  task automatic t_readonly();
    logic [7:0] s, c;
    flg = 5'h15;
    wr(8'h00, 8'hFF, 8'hE0, 1'h1);
    rd(8'h00, s, c);
    chk("status after write", s, 8'h15);
    chk("control after status write", c, ctrl_exp);
    outs(ctrl_exp);
  endtask

  // strap change, wrong address, lockout, abandoned write
  task automatic t_refuse();
    logic [7:0] s, c;
    logic a;
    strap = 2'h2;
    host_sel = 2'h2;
    repeat (20) @(negedge clk);
    ctrl_exp = 8'h06;
    wr(8'h01, 8'h00, ctrl_exp, 1'h1);
    outs(ctrl_exp);
    host_sel = 2'h1;
    wr(8'h01, 8'h00, 8'h01, 1'h0);
    host_sel = 2'h2;
    uvlo = 1'h1;
    repeat (20) @(negedge clk);
    wr(8'h01, ctrl_exp, ctrl_exp, 1'h0);
    uvlo = 1'h0;
    repeat (20) @(negedge clk);
    host.start_c();
    host.byte_o({`SC_ADDR_FIXED, host_sel, 1'h0}, a);
    host.byte_o(8'h01, a);
    host.stop_c();
    rd(8'h01, c, s);
    chk("control kept", c, ctrl_exp);
    outs(ctrl_exp);
  endtask

  // ****************************************
  // run control
  // ****************************************
  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", checked, bad_count);
    if (bad_count == 0 && checked > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask

  // main sequence
  initial begin
    clk = 1'h0;
    link_clk = 1'h0;
    reset = 1'h1;
    uvlo = 1'h0;
    strap = 2'h0;
    host_sel = 2'h0;
    flg = 5'h00;
    ctrl_exp = 8'h00;
    bad_count = 0;
    checked = 0;
    repeat (4) @(posedge clk);
    @(negedge clk);
    reset = 1'h0;
    repeat (10) @(negedge clk);
    t_power();
    t_levels();
    t_status();
    t_readonly();
    t_refuse();
    report_and_stop();
  end

  // hang guard: the scenarios need about 41000 clk cycles
  initial begin
    repeat (80000) @(posedge clk);
    bad_count++;
    report_and_stop();
  end
endmodule
`default_nettype wire
